// >>> core/dc_level_meter.sv
// Notes on behaviour
// - measure the ADC channel only while the enable bit is set.
// - filter select clear gives sinc average over 2^D; set gives low-pass IIR.
// - order field codes D directly, 1 to 20; software avoids 0 and above 20.
// - hold bit clear refreshes result; set freezes result for coherent reading.
// - IIR output mode clear tracks filter; set takes value before each clearing.
// - averaging time 0 is infinite; n of 1..20 clears every 2^n periods.
// - result bits 23..16 read back at high byte register, reset zero.
// - result bits 15..8 read back at middle byte register, reset zero.
// - result bits 7..0 read back at low byte register, reset zero.
`timescale 1ns/10ps
`default_nettype none

module dc_level_meter
  import dc_meas_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire reg_req_t                reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire logic signed [RES_W-1:0] adc_sample,
  input  wire logic                    adc_sample_valid
);

  dc_state_t st_reg;
  dc_state_t st_next;

  // keep the order inside 1..20 so a stray code cannot overflow the accumulator
  function automatic logic [4:0] clamp_order(input logic [4:0] code);
    if (code < ORDER_MIN) begin
      return ORDER_MIN;
    end else if (code > ORDER_MAX) begin
      return ORDER_MAX;
    end
    return code;
  endfunction

  // last count of a 2^n window
  function automatic logic [CNT_W-1:0] win_last(input logic [4:0] n);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    return CNT_W'((one << n) - one);
  endfunction

  function automatic logic signed [ACC_W-1:0] scale(input logic signed [ACC_W-1:0] v,
                                                     input logic [4:0] d);
    return v >>> d;
  endfunction

  logic                    en;
  logic                    iir_sel;
  logic                    hold;
  logic                    omode;
  logic [4:0]              ord;
  logic [4:0]              avg_n;
  logic signed [ACC_W-1:0] x_ext;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] iir_acc;
  logic signed [ACC_W-1:0] new_val;
  logic                    sinc_done;
  logic                    win_done;
  logic                    upd;

  assign en      = st_reg.ctl_a[EN_BIT];
  assign iir_sel = st_reg.ctl_a[IIR_BIT];
  assign ord     = clamp_order(st_reg.ctl_a[ORDER_MSB:0]);
  assign hold    = st_reg.ctl_b[HOLD_BIT];
  assign omode   = st_reg.ctl_b[OMODE_BIT];
  assign avg_n   = st_reg.ctl_b[AVG_MSB:0];
  assign x_ext   = ACC_W'(adc_sample);

  // filter datapath terms; iir keeps y scaled by 2^D so no fraction is lost
  assign sum       = st_reg.acc + x_ext;
  assign iir_acc   = sum - scale(st_reg.acc, ord);
  assign sinc_done = (st_reg.cnt >= win_last(ord));
  assign win_done  = (avg_n != 5'h00) && (st_reg.win >= win_last(avg_n));

  // next state: register writes, filter step, result refresh, read data
  always_comb begin
    st_next  = st_reg;
    new_val  = '0;
    upd      = 1'b0;
    if (reg_req.wr) begin
      if (reg_req.addr == CTL_A_OFS) begin
        st_next.ctl_a = reg_req.wdata;
      end else if (reg_req.addr == CTL_B_OFS) begin
        st_next.ctl_b = reg_req.wdata;
      end
    end
    if (!en) begin
      // filter restarts clean on the next enable, result is left alone
      st_next.acc = '0;
      st_next.cnt = '0;
      st_next.win = '0;
    end else if (adc_sample_valid) begin
      if (!iir_sel) begin
        if (sinc_done) begin
          new_val     = scale(sum, ord);
          upd         = 1'b1;
          st_next.acc = '0;
          st_next.cnt = '0;
        end else begin
          st_next.acc = sum;
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end else begin
        new_val     = scale(iir_acc, ord);
        upd         = !omode;
        st_next.acc = iir_acc;
        st_next.win = st_reg.win + 1'b1;
        if (win_done) begin
          upd         = 1'b1;
          st_next.acc = '0;
          st_next.win = '0;
        end
      end
    end
    if (upd && !hold) begin
      st_next.result = new_val[RES_W-1:0];
    end
    // read data follows the address one cycle later; unmapped reads zero
    if (reg_req.addr == CTL_A_OFS) begin
      st_next.rdata = st_reg.ctl_a;
    end else if (reg_req.addr == CTL_B_OFS) begin
      st_next.rdata = st_reg.ctl_b;
    end else if (reg_req.addr == RES_HI_OFS) begin
      st_next.rdata = st_reg.result[23:16];
    end else if (reg_req.addr == RES_MID_OFS) begin
      st_next.rdata = st_reg.result[15:8];
    end else if (reg_req.addr == RES_LO_OFS) begin
      st_next.rdata = st_reg.result[7:0];
    end else begin
      st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.ctl_a  <= CTL_A_RST;
      st_reg.ctl_b  <= CTL_B_RST;
      st_reg.acc    <= '0;
      st_reg.cnt    <= '0;
      st_reg.win    <= '0;
      st_reg.result <= RES_RST;
      st_reg.rdata  <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;

  // checks
  property p_off_idle;
    @(posedge clk) disable iff (!arst_n) !en |=> (st_reg.acc == '0 && st_reg.cnt == '0);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("filter state not cleared while disabled");

  property p_off_keep;
    @(posedge clk) disable iff (!arst_n) !en |=> $stable(st_reg.result);
  endproperty
  a_off_keep: assert property (p_off_keep) else $error("result changed while disabled");

  property p_sinc_update;
    @(posedge clk) disable iff (!arst_n)
      en && !iir_sel && adc_sample_valid && !hold && ord == 5'h01 && st_reg.cnt == '0
      ##1 en && !iir_sel && adc_sample_valid && !hold && ord == 5'h01
      |=> st_reg.result == RES_W'((ACC_W'($past(adc_sample, 2)) + ACC_W'($past(adc_sample))) >>> 1);
  endproperty
  a_sinc_update: assert property (p_sinc_update) else $error("sinc pair average wrong");

  property p_order_range;
    @(posedge clk) disable iff (!arst_n) ord >= ORDER_MIN && ord <= ORDER_MAX;
  endproperty
  a_order_range: assert property (p_order_range) else $error("order outside 1..20");

  // a legal code must reach the filter untouched, the clamp only guards stray codes
  property p_order_direct;
    @(posedge clk) disable iff (!arst_n)
      st_reg.ctl_a[ORDER_MSB:0] >= ORDER_MIN && st_reg.ctl_a[ORDER_MSB:0] <= ORDER_MAX
      |-> ord == st_reg.ctl_a[ORDER_MSB:0];
  endproperty
  a_order_direct: assert property (p_order_direct) else $error("order code not used directly");

  property p_hold;
    @(posedge clk) disable iff (!arst_n) hold |=> $stable(st_reg.result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved under hold");

  property p_omode_quiet;
    @(posedge clk) disable iff (!arst_n) en && iir_sel && omode && !win_done |=> $stable(st_reg.result);
  endproperty
  a_omode_quiet: assert property (p_omode_quiet) else $error("result moved between clears");

  property p_window_clear;
    @(posedge clk) disable iff (!arst_n)
      en && iir_sel && adc_sample_valid && win_done |=> st_reg.acc == '0 && st_reg.win == '0;
  endproperty
  a_window_clear: assert property (p_window_clear) else $error("iir not cleared at window end");

  property p_rd_hi;
    @(posedge clk) disable iff (!arst_n) reg_req.addr == RES_HI_OFS |=> reg_rdata == $past(st_reg.result[23:16]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high byte readback wrong");

  property p_rd_mid;
    @(posedge clk) disable iff (!arst_n) reg_req.addr == RES_MID_OFS |=> reg_rdata == $past(st_reg.result[15:8]);
  endproperty
  a_rd_mid: assert property (p_rd_mid) else $error("middle byte readback wrong");

  property p_rd_lo;
    @(posedge clk) disable iff (!arst_n) reg_req.addr == RES_LO_OFS |=> reg_rdata == $past(st_reg.result[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low byte readback wrong");

  // main scenarios
  property p_cv_sinc;
    @(posedge clk) disable iff (!arst_n) en && !iir_sel && adc_sample_valid && sinc_done && !hold;
  endproperty
  c_cv_sinc: cover property (p_cv_sinc);

  property p_cv_clear;
    @(posedge clk) disable iff (!arst_n) en && iir_sel && omode && adc_sample_valid && win_done;
  endproperty
  c_cv_clear: cover property (p_cv_clear);

  property p_cv_hold;
    @(posedge clk) disable iff (!arst_n) hold && en && adc_sample_valid;
  endproperty
  c_cv_hold: cover property (p_cv_hold);

endmodule

`default_nettype wire

// >>> core/dc_meas_pkg.sv
package dc_meas_pkg;

  // register byte offsets
  localparam logic [7:0] CTL_A_OFS   = 8'h66;
  localparam logic [7:0] CTL_B_OFS   = 8'h67;
  localparam logic [7:0] RES_HI_OFS  = 8'h68;
  localparam logic [7:0] RES_MID_OFS = 8'h69;
  localparam logic [7:0] RES_LO_OFS  = 8'h6a;

  // reset values
  localparam logic [7:0]  CTL_A_RST = 8'h00;
  localparam logic [7:0]  CTL_B_RST = 8'h00;
  localparam logic [23:0] RES_RST   = 24'h000000;

  // control a fields
  localparam int EN_BIT    = 7;
  localparam int IIR_BIT   = 5;
  localparam int ORDER_MSB = 4;
  // control b fields
  localparam int HOLD_BIT  = 6;
  localparam int OMODE_BIT = 5;
  localparam int AVG_MSB   = 4;

  // order range
  localparam logic [4:0] ORDER_MIN = 5'h01;
  localparam logic [4:0] ORDER_MAX = 5'h14;

  // data widths
  localparam int RES_W = 24;
  localparam int CNT_W = 20;
  localparam int ACC_W = RES_W + CNT_W;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]              ctl_a;
    logic [7:0]              ctl_b;
    logic signed [ACC_W-1:0] acc;
    logic [CNT_W-1:0]        cnt;
    logic [CNT_W-1:0]        win;
    logic [RES_W-1:0]        result;
    logic [7:0]              rdata;
  } dc_state_t;

endpackage

// >>> testbench/adc_dc_level_measurement_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module adc_dc_level_measurement_tb;
  import dc_meas_pkg::*;
  logic                    clk;
  logic                    arst_n;
  reg_req_t                req;
  logic [7:0]              reg_rdata;
  logic signed [RES_W-1:0] adc_sample;
  logic                    adc_sample_valid;
  int                      mismatches;
  int                      compares;
  // bench copy of the filter, stepped once per sample taken
  logic signed [ACC_W-1:0] m_acc, m_new, m_sh;
  logic [CNT_W:0]          m_cnt, m_win;
  logic [RES_W-1:0]        m_res;
  logic                    m_en, m_iir, m_om, m_hold;
  logic [4:0]              m_d, m_n;
  logic [7:0]              b;
  logic [31:0]             r;
  // test table: filter kind, order, output mode, window
  logic                    tiir [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic                    tom [6]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [4:0]              td [6]   = '{5'h01, 5'h03, 5'h02, 5'h02, 5'h01, 5'h05};
  logic [4:0]              tn [6]   = '{5'h00, 5'h00, 5'h00, 5'h02, 5'h03, 5'h00};

  dc_level_meter dut_u (
    .clk              (clk),
    .arst_n           (arst_n),
    .reg_req          (req),
    .reg_rdata        (reg_rdata),
    .adc_sample       (adc_sample),
    .adc_sample_valid (adc_sample_valid)
  );

  // free-running 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // two edges waited: address taken and data registered on the first, slack on the second
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(posedge clk);
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  task automatic chk_res(input logic [RES_W-1:0] e);
    logic [7:0] h, m, l;
    rd(RES_HI_OFS, h);
    rd(RES_MID_OFS, m);
    rd(RES_LO_OFS, l);
    `CHK("result", e, {h, m, l})
  endtask

  task automatic cfg(input logic en, iir, om, hold, input logic [4:0] d, n);
    wr(CTL_B_OFS, {1'b0, hold, om, n});
    wr(CTL_A_OFS, {en, 1'b0, iir, d});
    {m_en, m_iir, m_om, m_hold, m_d, m_n} = {en, iir, om, hold, d, n};
    if (!en) {m_acc, m_cnt, m_win} = '0;
  endtask

  // step the bench model by one sample taken
  function automatic void step(input logic signed [RES_W-1:0] x);
    logic fin;
    if (!m_en) return;
    m_new = m_iir ? m_acc + x - (m_acc >>> m_d) : m_acc + x;
    fin = m_iir ? (m_n != 0 && m_win == (1 << m_n) - 1) : (m_cnt == (1 << m_d) - 1);
    m_sh = m_new >>> m_d;
    if (!m_hold && (m_iir ? (!m_om || fin) : fin)) m_res = m_sh[RES_W-1:0];
    m_acc = fin ? '0 : m_new;
    m_cnt = fin ? '0 : m_cnt + 1'b1;
    m_win = fin ? '0 : m_win + 1'b1;
  endfunction

  // drive one sample, then step the model
  task automatic smp(input logic signed [RES_W-1:0] x);
    @(posedge clk);
    adc_sample <= x;
    adc_sample_valid <= 1'b1;
    @(posedge clk);
    adc_sample_valid <= 1'b0;
    step(x);
  endtask

  // two random samples on back-to-back edges, valid held high between them
  task automatic pair();
    logic [31:0] r0;
    logic [31:0] r1;
    r0 = $urandom;
    r1 = $urandom;
    @(posedge clk);
    adc_sample <= r0[23:0];
    adc_sample_valid <= 1'b1;
    @(posedge clk);
    adc_sample <= r1[23:0];
    step(r0[23:0]);
    @(posedge clk);
    adc_sample_valid <= 1'b0;
    step(r1[23:0]);
  endtask

  task automatic rnd_smp(input int k);
    repeat (k) begin
      r = $urandom;
      smp(r[23:0]);
    end
  endtask

  task automatic print_verdict();
    $display("counts: compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("run timed out");
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    req = '0;
    adc_sample = '0;
    adc_sample_valid = 1'b0;
    {mismatches, compares} = '0;
    {m_acc, m_cnt, m_win, m_res, m_en, m_iir, m_om, m_hold, m_d, m_n} = '0;
    void'($urandom(32'h30fde73f));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, read-only result, unmapped read, reserved bits kept
    for (int a = 'h66; a <= 'h6a; a++) begin
      rd(a[7:0], b);
      `CHK("reset value", 8'h00, b)
    end
    wr(RES_HI_OFS, 8'hff);
    chk_res(RES_RST);
    rd(8'h70, b);
    `CHK("unmapped", 8'h00, b)
    // reserved bits stay zero, order and window at their top legal code
    wr(CTL_A_OFS, 8'h34);
    rd(CTL_A_OFS, b);
    `CHK("ctl a", 8'h34, b)
    wr(CTL_B_OFS, 8'h54);
    rd(CTL_B_OFS, b);
    `CHK("ctl b", 8'h54, b)
    $display("test registers done");
    // each filter setting, checked after every sample, extremes first
    for (int t = 0; t < 6; t++) begin
      cfg(1'b0, tiir[t], tom[t], 1'b0, td[t], tn[t]);
      cfg(1'b1, tiir[t], tom[t], 1'b0, td[t], tn[t]);
      for (int i = 0; i < 40; i++) begin
        r = (i < 4) ? 32'h007fffff : (i < 8) ? 32'h00800000 : $urandom;
        smp(r[23:0]);
        chk_res(m_res);
      end
      $display("test filter %0d done", t);
    end
    // hold freezes result, release resumes
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 5'h01, 5'h00);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 5'h01, 5'h00);
    pair();
    chk_res(m_res);
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 5'h01, 5'h00);
    rnd_smp(4);
    chk_res(m_res);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 5'h01, 5'h00);
    rnd_smp(2);
    chk_res(m_res);
    $display("test hold done");
    // disabled: samples ignored, result kept, clean restart
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 5'h02, 5'h00);
    rnd_smp(3);
    chk_res(m_res);
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 5'h02, 5'h00);
    rnd_smp(3);
    chk_res(m_res);
    $display("test enable done");
    print_verdict();
  end
endmodule
`default_nettype wire
